// ### logic/sse_exec_unit.sv
// execution unit for locked swap, soft trap and coprocessor data ops
// What this block does
// RULE1 - run only when the condition passes
// RULE2 - read and write form one uninterruptible pair
// RULE3 - read base, write source, old value to dest
// RULE4 - lock high across both swap accesses
// RULE5 - memory manager keeps the bus while locked
// RULE6 - byte bit set swaps byte, clear swaps word
// RULE7 - swap uses load and store lane handling
// RULE8 - abort on either access takes data abort
// RULE9 - swap costs 1S 2N 1I
// RULE10 - soft trap: supervisor mode, save status, vector 0x08
// RULE11 - link gets address of following word
// RULE12 - flag-setting return restores status and program
// RULE13 - low 24 bits of soft trap ignored
// RULE14 - soft trap costs 2S 1N
// RULE15 - every coprocessor op takes undefined trap
// RULE16 - no result and no wait for coprocessor
// RULE17 - only bit 4 and bits 31..24 decoded
// RULE18 - coprocessors ignore foreign number fields
// RULE19 - coprocessor op costs 1S plus busy-wait cycles
`timescale 1ns/1ps
`default_nettype none
module sse_exec_unit #(
	parameter int BW_W = 8,
	parameter logic [BW_W-1:0] BUSY_CYCLES = BW_W'(sse_pkg::BUSY_WAIT)
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	output logic instr_ready,
	input wire logic [31:0] instr,
	input wire logic [31:0] instr_addr,
	input wire logic [31:0] base_val,
	input wire logic [31:0] src_val,
	input wire logic big_endian,
	input wire logic flag_we,
	input wire logic [3:0] flag_in,
	output logic mem_req,
	output logic mem_write,
	output logic mem_lock,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic [3:0] mem_be,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ack,
	input wire logic mem_abort,
	output logic irq_hold,
	output sse_pkg::sse_cyc_t cyc_type,
	output logic wb_en,
	output logic [3:0] wb_idx,
	output logic [31:0] wb_data,
	output logic pc_load,
	output logic [31:0] pc_value,
	output logic trap_data_abort,
	output logic trap_undef,
	output logic [31:0] status_word,
	output logic [31:0] saved_status,
	output logic [31:0] link_reg
);
	sse_pkg::sse_state_t state;
	logic cond_pass, take, exec;
	logic is_swap, is_trap, is_cdp, is_ret;
	logic byte_mode, ab_seen;
	logic [1:0] lane;
	logic [3:0] dest_idx;
	logic [31:0] read_val;
	logic [BW_W-1:0] bw_cnt;

	function automatic logic sse_match(input logic [31:0] w, input logic [31:0] m,
		input logic [31:0] v);
		return (w & m) == v;
	endfunction

	function automatic logic [31:0] sse_rotr(input logic [31:0] w, input logic [1:0] sh);
		unique case (sh)
			2'b00: return w;
			2'b01: return {w[7:0], w[31:8]};
			2'b10: return {w[15:0], w[31:16]};
			2'b11: return {w[23:0], w[31:24]};
		endcase
	endfunction

	// RULE1 - condition gate
	sse_cond_eval u_cond (
		.cond(instr[sse_pkg::COND_LSB +: 4]),
		.flags(status_word[sse_pkg::FLAG_LSB +: 4]),
		.pass(cond_pass)
	);

	assign instr_ready = state == sse_pkg::ST_IDLE;
	assign take = instr_valid && instr_ready;
	assign exec = take && cond_pass;
	assign is_swap = sse_match(instr, sse_pkg::SWAP_MASK, sse_pkg::SWAP_MATCH);
	// RULE13 - comment field ignored
	assign is_trap = sse_match(instr, sse_pkg::TRAP_MASK, sse_pkg::TRAP_MATCH);
	// RULE17 - narrow decode
	assign is_cdp = sse_match(instr, sse_pkg::CDP_MASK, sse_pkg::CDP_MATCH);
	assign is_ret = sse_match(instr, sse_pkg::RET_MASK, sse_pkg::RET_MATCH);

	// RULE2 - locked pair
	// RULE4 - lock across read and write
	assign mem_req = state == sse_pkg::ST_SW_RD || state == sse_pkg::ST_SW_WR;
	assign mem_write = state == sse_pkg::ST_SW_WR;
	assign mem_lock = mem_req;
	// interrupts are held off through the swap's internal cycle too, not only while locked
	assign irq_hold = state inside {sse_pkg::ST_SW_RD, sse_pkg::ST_SW_WR,
		sse_pkg::ST_SW_INT};

	// RULE9 - swap cycle classes
	// RULE14 - soft trap cycle classes
	// RULE19 - coprocessor cycle classes
	always_comb begin
		unique case (state)
			sse_pkg::ST_SW_RD, sse_pkg::ST_SW_WR, sse_pkg::ST_TR_N:
				cyc_type = sse_pkg::CYC_NSEQ;
			sse_pkg::ST_SW_INT, sse_pkg::ST_CP_BW: cyc_type = sse_pkg::CYC_INT;
			sse_pkg::ST_SW_SEQ, sse_pkg::ST_TR_S1, sse_pkg::ST_TR_S2, sse_pkg::ST_CP_S:
				cyc_type = sse_pkg::CYC_SEQ;
			default: cyc_type = sse_pkg::CYC_NONE;
		endcase
	end

	// sequencing
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= sse_pkg::ST_IDLE;
		end else begin
			unique case (state)
				sse_pkg::ST_IDLE: begin
					if (exec && is_swap) begin
						state <= sse_pkg::ST_SW_RD;
					end else if (exec && is_trap) begin
						state <= sse_pkg::ST_TR_N;
					end else if (exec && is_cdp) begin
						state <= sse_pkg::ST_CP_S;
					end
				end
				// RULE5 - memory manager may stretch each access but must not split them
				sse_pkg::ST_SW_RD: if (mem_ack) state <= sse_pkg::ST_SW_WR;
				sse_pkg::ST_SW_WR: if (mem_ack) state <= sse_pkg::ST_SW_INT;
				sse_pkg::ST_SW_INT: state <= sse_pkg::ST_SW_SEQ;
				sse_pkg::ST_SW_SEQ: state <= sse_pkg::ST_IDLE;
				sse_pkg::ST_TR_N: state <= sse_pkg::ST_TR_S1;
				sse_pkg::ST_TR_S1: state <= sse_pkg::ST_TR_S2;
				sse_pkg::ST_TR_S2: state <= sse_pkg::ST_IDLE;
				// RULE16 - no coprocessor handshake is waited on
				sse_pkg::ST_CP_S: begin
					state <= (BUSY_CYCLES == '0) ? sse_pkg::ST_IDLE : sse_pkg::ST_CP_BW;
				end
				sse_pkg::ST_CP_BW: begin
					if (bw_cnt == BUSY_CYCLES - BW_W'(1)) state <= sse_pkg::ST_IDLE;
				end
				default: state <= sse_pkg::ST_IDLE;
			endcase
		end
	end

	// busy-wait counter, idle without a coprocessor
	always_ff @(posedge clk) begin
		if (sys_rst || state != sse_pkg::ST_CP_BW) begin
			bw_cnt <= '0;
		end else begin
			bw_cnt <= bw_cnt + BW_W'(1);
		end
	end

	// RULE3 - address from base, data from source
	// RULE6 - byte or word select
	// RULE7 - store lane placement
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_addr <= '0;
			mem_wdata <= '0;
			mem_be <= '0;
			byte_mode <= 1'b0;
			lane <= '0;
			dest_idx <= '0;
		end else if (exec && is_swap) begin
			mem_addr <= base_val;
			byte_mode <= instr[sse_pkg::BYTE_BIT];
			dest_idx <= instr[sse_pkg::DEST_LSB +: 4];
			lane <= base_val[1:0] ^ {2{big_endian}};
			if (instr[sse_pkg::BYTE_BIT]) begin
				mem_wdata <= {4{src_val[7:0]}};
				mem_be <= 4'h1 << (base_val[1:0] ^ {2{big_endian}});
			end else begin
				mem_wdata <= src_val;
				mem_be <= 4'hf;
			end
		end
	end

	// RULE7 - load lane extraction and word rotation
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			read_val <= '0;
		end else if (state == sse_pkg::ST_SW_RD && mem_ack) begin
			if (byte_mode) begin
				read_val <= {24'h00_0000, mem_rdata[{lane, 3'b000} +: 8]};
			end else begin
				read_val <= sse_rotr(mem_rdata, mem_addr[1:0]);
			end
		end
	end

	// RULE8 - abort on either access, set wins over the clear at start
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ab_seen <= 1'b0;
		end else if (mem_req && mem_ack && mem_abort) begin
			ab_seen <= 1'b1;
		end else if (exec && is_swap) begin
			ab_seen <= 1'b0;
		end
	end

	// RULE3 - old memory value to destination after the write
	// RULE8 - aborted swap leaves the destination alone
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wb_en <= 1'b0;
			wb_idx <= '0;
			wb_data <= '0;
			trap_data_abort <= 1'b0;
		end else begin
			wb_en <= state == sse_pkg::ST_SW_INT && !ab_seen;
			trap_data_abort <= state == sse_pkg::ST_SW_INT && ab_seen;
			if (state == sse_pkg::ST_SW_INT) begin
				wb_idx <= dest_idx;
				wb_data <= read_val;
			end
		end
	end

	// RULE15 - absent coprocessor, undefined trap for its ops
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trap_undef <= 1'b0;
		end else begin
			trap_undef <= (state == sse_pkg::ST_CP_S && BUSY_CYCLES == '0) ||
				(state == sse_pkg::ST_CP_BW && bw_cnt == BUSY_CYCLES - BW_W'(1));
		end
	end

	// RULE10 - supervisor entry, status save and fixed vector
	// RULE11 - link to the following word
	// RULE12 - return restores status from the saved copy
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_word <= sse_pkg::STATUS_RST;
			saved_status <= '0;
			link_reg <= '0;
			pc_load <= 1'b0;
			pc_value <= '0;
		end else begin
			pc_load <= 1'b0;
			if (exec && is_trap) begin
				saved_status <= status_word;
				status_word <= {status_word[31:5], sse_pkg::MODE_SVC};
				link_reg <= instr_addr + sse_pkg::LINK_STEP;
				pc_load <= 1'b1;
				pc_value <= sse_pkg::TRAP_VECTOR;
			end else if (exec && is_ret && status_word[4:0] == sse_pkg::MODE_SVC) begin
				// the restore overrides any flag write in the same cycle
				status_word <= saved_status;
				pc_load <= 1'b1;
				pc_value <= link_reg;
			end else if (flag_we) begin
				status_word[sse_pkg::FLAG_LSB +: 4] <= flag_in;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence swap_issue;
		exec && is_swap;
	endsequence
	sequence rd_done;
		state == sse_pkg::ST_SW_RD && mem_ack;
	endsequence
	sequence wr_done_clean;
		state == sse_pkg::ST_SW_WR && mem_ack && !mem_abort && !ab_seen;
	endsequence

	a_swap_read_first: assert property (swap_issue |=> mem_req && !mem_write && mem_lock
		&& mem_addr == $past(base_val)) // RULE3
		else $error("swap did not start with a locked read of the base address");
	a_lock_both: assert property (rd_done |=> mem_write && mem_lock && irq_hold) // RULE4
		else $error("lock dropped between swap read and write");
	a_swap_word_data: assert property ((swap_issue and !instr[sse_pkg::BYTE_BIT]) |=>
		mem_wdata == $past(src_val) && mem_be == 4'hf) // RULE6
		else $error("word swap stores wrong data or lanes");
	a_swap_writeback: assert property (wr_done_clean |=> ##1 wb_en && !trap_data_abort
		&& wb_data == $past(read_val, 2)) // RULE3
		else $error("swap destination not written with old memory value");
	a_abort_trap: assert property (state == sse_pkg::ST_SW_WR && mem_ack && mem_abort |=>
		##1 trap_data_abort && !wb_en) // RULE8
		else $error("aborted swap did not raise data abort");
	a_trap_entry: assert property (exec && is_trap |=> pc_load
		&& pc_value == sse_pkg::TRAP_VECTOR && status_word[4:0] == sse_pkg::MODE_SVC
		&& saved_status == $past(status_word)
		&& link_reg == $past(instr_addr) + sse_pkg::LINK_STEP) // RULE10
		else $error("soft trap entry state wrong");
	a_trap_length: assert property (exec && is_trap |=> !instr_ready [*3] ##1 instr_ready)
		// RULE14
		else $error("soft trap does not take three cycles");
	a_cond_skip: assert property (take && !cond_pass |=> instr_ready && !pc_load
		&& !mem_req) // RULE1
		else $error("failed condition still had an effect");
	a_cdp_undef: assert property (exec && is_cdp |-> ##[2:260] trap_undef) // RULE15
		else $error("coprocessor op did not raise undefined trap");
	a_ret_restore: assert property (exec && is_ret && status_word[4:0] == sse_pkg::MODE_SVC
		|=> pc_load && pc_value == $past(link_reg)
		&& status_word == $past(saved_status)) // RULE12
		else $error("return did not restore status and program counter");
endmodule
`default_nettype wire

// ### logic/sse_pkg.sv
// shared constants and types for the swap, soft trap and coprocessor op unit
package sse_pkg;
	// instruction classes are recognised by mask and match
	localparam logic [31:0] SWAP_MASK = 32'h0fb0_0ff0;
	localparam logic [31:0] SWAP_MATCH = 32'h0100_0090;
	// the low 24 bits of a soft trap are a comment and stay out of the mask
	localparam logic [31:0] TRAP_MASK = 32'h0f00_0000;
	localparam logic [31:0] TRAP_MATCH = 32'h0f00_0000;
	// coprocessor op: only bit 4 and bits 27..24 are in the mask, the condition field is checked apart
	localparam logic [31:0] CDP_MASK = 32'h0f00_0010;
	localparam logic [31:0] CDP_MATCH = 32'h0e00_0000;
	// flag-setting move of the link register into the program counter
	localparam logic [31:0] RET_MASK = 32'h0fff_ffff;
	localparam logic [31:0] RET_MATCH = 32'h01b0_f00e;
	localparam int COND_LSB = 28;
	localparam int BYTE_BIT = 22;
	localparam int BASE_LSB = 16;
	localparam int DEST_LSB = 12;
	localparam int FLAG_LSB = 28;
	localparam logic [31:0] TRAP_VECTOR = 32'h0000_0008;
	localparam logic [31:0] LINK_STEP = 32'h0000_0004;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [31:0] STATUS_RST = 32'h0000_00d3;
	localparam int BUSY_WAIT = 0;

	typedef enum logic [1:0] {
		CYC_NONE = 2'b00,
		CYC_SEQ = 2'b01,
		CYC_NSEQ = 2'b10,
		CYC_INT = 2'b11
	} sse_cyc_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_SW_RD = 4'b0001,
		ST_SW_WR = 4'b0010,
		ST_SW_INT = 4'b0011,
		ST_SW_SEQ = 4'b0100,
		ST_TR_N = 4'b0101,
		ST_TR_S1 = 4'b0110,
		ST_TR_S2 = 4'b0111,
		ST_CP_S = 4'b1000,
		ST_CP_BW = 4'b1001
	} sse_state_t;
endpackage

// ### logic/sse_cond_eval.sv
// condition field check against the flags
`timescale 1ns/1ps
`default_nettype none
module sse_cond_eval (
	input wire logic [3:0] cond,
	input wire logic [3:0] flags,
	output logic pass
);
	logic n, z, c, v;
	assign n = flags[3];
	assign z = flags[2];
	assign c = flags[1];
	assign v = flags[0];
	always_comb begin
		unique case (cond)
			4'h0: pass = z;
			4'h1: pass = !z;
			4'h2: pass = c;
			4'h3: pass = !c;
			4'h4: pass = n;
			4'h5: pass = !n;
			4'h6: pass = v;
			4'h7: pass = !v;
			4'h8: pass = c && !z;
			4'h9: pass = !c || z;
			4'ha: pass = n == v;
			4'hb: pass = n != v;
			4'hc: pass = !z && (n == v);
			4'hd: pass = z || (n != v);
			4'he: pass = 1'b1;
			4'hf: pass = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ### testbench/sse_mem_model.sv
// memory manager and memory behind the swap port
`timescale 1ns/1ps
`default_nettype none
module sse_mem_model (
	input wire logic clk,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic mem_lock,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [3:0] mem_be,
	input wire logic slow,
	input wire logic ab_rd,
	input wire logic ab_wr,
	output logic [31:0] mem_rdata,
	output logic mem_ack,
	output logic mem_abort
);
	logic [31:0] mem [0:15];
	logic [1:0] wait_cnt = 2'h0;
	logic hit, ready;
	assign hit = mem_write ? ab_wr : ab_rd;
	// sole requester, so a locked pair is never split
	// an unlocked request is never answered, so a dropped lock hangs the bench
	assign ready = !slow || wait_cnt == 2'h3;
	assign mem_ack = mem_req && mem_lock && ready;
	assign mem_abort = mem_ack && hit;
	// outside an answered read the data lines show the inverse, so no stale value passes
	assign mem_rdata = (mem_ack && !mem_write) ? mem[mem_addr[5:2]] : ~mem[mem_addr[5:2]];
	always @(posedge clk) begin
		if (mem_ack) begin
			wait_cnt <= 2'h0;
			for (int i = 0; i < 4; i++) begin
				// an aborted store must not reach memory
				if (mem_write && !hit && mem_be[i]) begin
					mem[mem_addr[5:2]][8*i+:8] <= mem_wdata[8*i+:8];
				end
			end
		end else if (mem_req) begin
			wait_cnt <= wait_cnt + 2'h1;
		end
	end
endmodule
`default_nettype wire

// ### testbench/swap_swi_coproc_op_execution_tb.sv
// self-checking bench for the swap, soft trap and coprocessor op unit
`timescale 1ns/1ps
`default_nettype none
module swap_swi_coproc_op_execution_tb;
	typedef struct packed {logic [1:0] k; logic [31:0] v, l, s, p;} sse_note_t;
	localparam int BUSY = 2;
	logic clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, big_endian = 1'b0, flag_we = 1'b0;
	logic slow = 1'b0, ab_rd = 1'b0, ab_wr = 1'b0;
	logic [3:0] flag_in = 4'h0, mem_be, wb_idx;
	logic [31:0] instr = 32'h0, instr_addr = 32'h0, base_val = 32'h0, src_val = 32'h0;
	logic instr_ready, mem_req, mem_write, mem_lock, mem_ack, mem_abort, irq_hold;
	logic wb_en, pc_load, trap_data_abort, trap_undef;
	logic [31:0] mem_addr, mem_wdata, mem_rdata, wb_data, pc_value, status_word, saved_status;
	logic [31:0] link_reg, st, sv, lk;
	logic [31:0] sh [0:15];
	sse_pkg::sse_cyc_t cyc_type;
	int miscompares = 0, cmp_count = 0, cycles = 0, n_s = 0, n_n = 0, n_i = 0;
	sse_note_t q[$];
	sse_note_t nt;
	sse_exec_unit #(.BW_W(8), .BUSY_CYCLES(8'h02)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.instr_valid(instr_valid), .instr_ready(instr_ready), .instr(instr), .instr_addr(instr_addr),
		.base_val(base_val), .src_val(src_val), .big_endian(big_endian), .flag_we(flag_we),
		.flag_in(flag_in), .mem_req(mem_req), .mem_write(mem_write), .mem_lock(mem_lock),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .mem_abort(mem_abort), .irq_hold(irq_hold), .cyc_type(cyc_type),
		.wb_en(wb_en), .wb_idx(wb_idx), .wb_data(wb_data), .pc_load(pc_load), .pc_value(pc_value),
		.trap_data_abort(trap_data_abort), .trap_undef(trap_undef), .status_word(status_word),
		.saved_status(saved_status), .link_reg(link_reg));
	sse_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_write(mem_write), .mem_lock(mem_lock),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .slow(slow), .ab_rd(ab_rd),
		.ab_wr(ab_wr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_abort(mem_abort));
	always #4 clk = ~clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			give_verdict();
		end
	end
	// watcher: cycle kinds per instruction, lock, and completion events
	always @(negedge clk) begin
		if (instr_valid && instr_ready) begin
			n_s = 0;
			n_n = 0;
			n_i = 0;
		end else begin
			n_s += int'(cyc_type == sse_pkg::CYC_SEQ);
			n_n += int'(cyc_type == sse_pkg::CYC_NSEQ);
			n_i += int'(cyc_type == sse_pkg::CYC_INT);
		end
		if (mem_req && !(mem_lock === 1'b1 && irq_hold === 1'b1)) chk("lock", 1, 0);
		if (wb_en || trap_data_abort || pc_load || trap_undef) begin
			if (q.size() == 0) begin
				chk("unexpected event", 0, 1);
			end else begin
				nt = q.pop_front();
				chk("kind", {30'h0, nt.k}, {30'h0, pc_load | trap_undef, trap_data_abort | trap_undef});
				if (nt.k == 2'h0) chk("wb_data", nt.v, wb_data);
				if (nt.k == 2'h0) chk("wb_idx", nt.l, {28'h0, wb_idx});
				if (nt.k == 2'h2) chk("pc_value", nt.v, pc_value);
				if (nt.k == 2'h2) chk("link_reg", nt.l, link_reg);
				if (nt.k == 2'h2) chk("status_word", nt.s, status_word);
				if (nt.k == 2'h2) chk("saved_status", nt.p, saved_status);
			end
		end
	end
	task automatic run(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] s);
		int n;
		instr <= ins;
		instr_addr <= a;
		base_val <= a;
		src_val <= s;
		instr_valid <= 1'b1;
		n = 0;
		do begin @(negedge clk); n++; end while (instr_ready !== 1'b1 && n < 300);
		@(posedge clk);
		instr_valid <= 1'b0;
		n = 0;
		do begin @(negedge clk); n++; end while (instr_ready !== 1'b1 && n < 300);
		@(posedge clk);
	endtask
	function automatic logic pass(input logic [3:0] c);
		return c == 4'he || (c == 4'h0 && st[30]) || (c == 4'h1 && !st[30]);
	endfunction
	task automatic swap(input logic [3:0] c, input logic byt, input logic big);
		logic [31:0] a, s, w, e;
		logic [3:0] rd;
		logic [1:0] ln;
		a = 32'h0000_1000 | ($urandom & 32'h3f);
		s = $urandom;
		rd = 4'($urandom);
		ln = a[1:0] ^ {big, big};
		w = sh[a[5:2]];
		e = byt ? {24'h0, w[8*ln+:8]} : 32'({w, w} >> (8 * a[1:0]));
		big_endian <= big;
		if (pass(c)) begin
			q.push_back('{(ab_rd | ab_wr) ? 2'h1 : 2'h0, e, {28'h0, rd}, 32'h0, 32'h0});
			if (!ab_wr && byt) sh[a[5:2]][8*ln+:8] = s[7:0];
			if (!ab_wr && !byt) sh[a[5:2]] = s;
		end
		run({c, 5'b00010, byt, 2'b00, 4'h2, rd, 8'h09, 4'h3}, a, s);
		if (pass(c) && !slow && !ab_rd && !ab_wr) chk("swap cycles", 32'h0201_0101, {8'(n_n), 8'(n_s), 8'(n_i), 8'h1});
	endtask
	task automatic trap(input logic [3:0] c);
		logic [31:0] a;
		a = $urandom & 32'hffff_fffc;
		if (pass(c)) begin
			sv = st;
			st[4:0] = sse_pkg::MODE_SVC;
			lk = a + sse_pkg::LINK_STEP;
			q.push_back('{2'h2, sse_pkg::TRAP_VECTOR, lk, st, sv});
		end
		run({c, 4'hf, 24'($urandom)}, a, 32'h0);
		if (pass(c)) chk("trap cycles", 32'h0102_0000, {8'(n_n), 8'(n_s), 8'(n_i), 8'h0});
	endtask
	task automatic ret;
		if (st[4:0] == sse_pkg::MODE_SVC) begin
			st = sv;
			q.push_back('{2'h2, lk, lk, sv, sv});
		end
		run(32'he1b0_f00e, 32'h0000_0200, 32'h0);
	endtask
	task automatic flags(input logic [3:0] f);
		flag_we <= 1'b1;
		flag_in <= f;
		@(posedge clk);
		flag_we <= 1'b0;
		st[31:28] = f;
	endtask
	initial begin
		void'($urandom(32'hd64c2e27));
		for (int i = 0; i < 16; i++) begin
			sh[i] = $urandom;
			u_mem.mem[i] = sh[i];
		end
		st = sse_pkg::STATUS_RST;
		sv = 32'h0;
		lk = 32'h0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk("reset status", sse_pkg::STATUS_RST, status_word);
		for (int i = 0; i < 40; i++) swap(4'he, 1'($urandom), 1'($urandom));
		slow <= 1'b1;
		for (int i = 0; i < 6; i++) swap(4'he, 1'($urandom), 1'($urandom));
		slow <= 1'b0;
		for (int i = 1; i < 4; i++) begin
			ab_rd <= i[0];
			ab_wr <= i[1];
			@(posedge clk);
			swap(4'he, 1'(i), 1'b0);
		end
		ab_rd <= 1'b0;
		ab_wr <= 1'b0;
		swap(4'h0, 1'b0, 1'b0);
		ret();
		flags(4'h4);
		swap(4'h0, 1'b1, 1'b0);
		swap(4'h1, 1'b0, 1'b0);
		trap(4'h1);
		trap(4'he);
		flags(4'h9);
		ret();
		ret();
		for (int cp = 0; cp < 16; cp++) begin
			q.push_back('{2'h3, 32'h0, 32'h0, 32'h0, 32'h0});
			run({8'hee, 12'($urandom), 4'(cp), 3'($urandom), 1'b0, 4'($urandom)}, 32'h0, 32'h0);
			chk("coproc cycles", BUSY + 256, n_i + 256 * n_s);
		end
		repeat (5) @(posedge clk);
		chk("pending events", 32'h0, q.size());
		give_verdict();
	end
endmodule
`default_nettype wire
